// [rtl/sfhp_consts.vh]
// Constants for the serial flash hold and lane-3 pin logic
`ifndef SFHP_CONSTS_VH
`define SFHP_CONSTS_VH
// Lane mode codes
`define SFHP_MODE_SINGLE 2'h0
`define SFHP_MODE_QIN 2'h1
`define SFHP_MODE_QOUT 2'h2
`define SFHP_MODE_W 2
// Shift register and bit counter widths
`define SFHP_BYTE_W 8
`define SFHP_CNT_W 3
`define SFHP_CNT_LAST 3'h7
`define SFHP_CNT_QLAST 3'h1
`define SFHP_CNT_RST 3'h0
`define SFHP_BYTE_RST 8'h00
// Synchroniser depth
`define SFHP_SYNC_W 2
// Float flag clear, chip select and clock at their idle high level
`define SFHP_SYNC_RST 3'h3
`define SFHP_SYNC_RST0 2'h0
// Lane pins idle high, so no hold is seen out of reset
`define SFHP_IO_RST 4'hf
// Clock history starts at the idle level, so reset makes no false edge
`define SFHP_SCK_RST 1'b1
`define SFHP_NIB_RST 4'h0
`define SFHP_OE_OFF 4'hf
`define SFHP_OE_ON 4'h0
`endif

// [rtl/sfhp_sync.v]
// Two-flop synchroniser bank for the serial pins
`timescale 1ns/1ps
module sfhp_sync
#(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
)
(
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Pins in, synchronised out
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      reg meta_q;
      reg stab_q;
      always @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          meta_q <= RST_VAL[i];
          stab_q <= RST_VAL[i];
        end
        else
        begin
          meta_q <= async_in[i];
          stab_q <= meta_q;
        end
      end
      assign sync_out[i] = stab_q;
    end
  endgenerate
endmodule

// [rtl/sfhp_top.v]
// Hold and lane-3 pin logic of the serial flash slave interface
// Behaviour
// (RQ1) Hold only pauses the transfer; selection and shift state are kept.
// (RQ2) While held, serial clock edges and serial input are ignored.
// (RQ3) While held, the serial output driver is released.
// (RQ4) Hold begins only while selected and with the serial clock low.
// (RQ5) Hold never touches an internal program or erase cycle.
// (RQ6) In quad program the hold pin is input lane 3, four bits per rise.
// (RQ7) In quad read the hold pin drives lane 3, updated on each fall.
// (RQ8) A floating hold pin reads as deasserted through a pull-up.
// (RQ9) Single lane captures on rising and shifts out on falling edges.
// (RQ10) Chip select falling starts and rising ends command decoding.
// (RQ11) Release of hold resumes at the exact bit where shifting stopped.
`timescale 1ns/1ps
`include "sfhp_consts.vh"
module sfhp_top
(
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Serial pins, sampled through synchronisers
  input wire cs_n_pin,
  input wire sck_pin,
  input wire [3:0] io_in,
  // Pull-up presence on lane 3, high when the pin is left floating
  input wire hold_float,
  // Lane mode from the command decoder
  input wire [1:0] lane_mode,
  // Data to send, one byte per load
  input wire [7:0] tx_byte,
  // Internal program or erase cycle busy
  input wire busy_in,
  // Pad drivers, enable low means driving
  output reg so_out,
  output reg so_oe_n,
  output reg [3:0] quad_out,
  output reg [3:0] quad_oe_n,
  // Received data and events
  output reg [7:0] rx_byte,
  output reg rx_valid,
  output reg tx_load,
  output reg frame_start,
  output reg frame_end,
  output reg hold_active,
  output reg busy_out
);
  wire [3:0] io_s;
  wire [2:0] ctl_s;
  wire float_s;
  wire cs_n_s;
  wire sck_s;
  wire hold_raw;
  reg cs_n_q;
  reg sck_q;
  reg hold_q;
  reg [7:0] sh_in_q;
  reg [7:0] sh_out_q;
  reg [2:0] cnt_q;
  reg [2:0] ocnt_q;
  reg hold_d;
  wire rise;
  wire fall;
  wire quad_in;
  wire quad_rd;
  wire [2:0] last;

  sfhp_sync #(.WIDTH(4), .RST_VAL(`SFHP_IO_RST)) u_io
  (
    .clk(clk),
    .nrst(nrst),
    .async_in(io_in),
    .sync_out(io_s)
  );

  // Float flag rides with the pins so lane 3 and its pull-up stay aligned
  sfhp_sync #(.WIDTH(3), .RST_VAL(`SFHP_SYNC_RST)) u_ctl
  (
    .clk(clk),
    .nrst(nrst),
    .async_in({hold_float, cs_n_pin, sck_pin}),
    .sync_out(ctl_s)
  );

  assign float_s = ctl_s[2];
  assign cs_n_s = ctl_s[1];
  assign sck_s = ctl_s[0];
  assign quad_in = (lane_mode == `SFHP_MODE_QIN);
  assign quad_rd = (lane_mode == `SFHP_MODE_QOUT);
  // Floating pin counts as high; lane 3 is data in quad modes
  assign hold_raw = ~(io_s[3] | float_s) & ~quad_in & ~quad_rd; // RQ8
  // Edges of the serial clock only count when not held
  assign rise = sck_s & ~sck_q & ~cs_n_s & ~hold_q; // RQ2
  assign fall = ~sck_s & sck_q & ~cs_n_s & ~hold_q; // RQ2
  assign last = (quad_in | quad_rd) ? `SFHP_CNT_QLAST : `SFHP_CNT_LAST;

  // Hold entry needs select and clock low; exit may happen any time
  always @*
  begin
    hold_d = hold_q;
    if (cs_n_s)
      hold_d = 1'b0;
    else if (!hold_q && hold_raw && !sck_s) // RQ4
      hold_d = 1'b1;
    else if (hold_q && !hold_raw)
      hold_d = 1'b0; // RQ11
  end

  // Pin history for edge detection, and the hold state itself
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cs_n_q <= 1'b1;
      sck_q <= `SFHP_SCK_RST;
      hold_q <= 1'b0;
    end
    else
    begin
      cs_n_q <= cs_n_s;
      sck_q <= sck_s;
      hold_q <= hold_d; // RQ1
    end
  end

  // Receive shifter; hold freezes it mid-byte instead of clearing it
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sh_in_q <= `SFHP_BYTE_RST;
      cnt_q <= `SFHP_CNT_RST;
      rx_byte <= `SFHP_BYTE_RST;
      rx_valid <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      if (cs_n_s)
        cnt_q <= `SFHP_CNT_RST; // RQ10
      else if (rise) // RQ1
      begin
        if (quad_in)
          sh_in_q <= {sh_in_q[3:0], io_s}; // RQ6
        else
          sh_in_q <= {sh_in_q[6:0], io_s[0]}; // RQ9
        if (cnt_q == last)
        begin
          cnt_q <= `SFHP_CNT_RST;
          rx_valid <= 1'b1;
          rx_byte <= quad_in ? {sh_in_q[3:0], io_s} :
                               {sh_in_q[6:0], io_s[0]};
        end
        else
          cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  // Transmit shifter; next byte taken while deselected or at byte end,
  // so tx_load marks the byte just taken and the following one is needed by the next byte end
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sh_out_q <= `SFHP_BYTE_RST;
      ocnt_q <= `SFHP_CNT_RST;
      tx_load <= 1'b0;
      so_out <= 1'b0;
      quad_out <= `SFHP_NIB_RST;
    end
    else
    begin
      tx_load <= 1'b0;
      if (cs_n_s)
      begin
        ocnt_q <= `SFHP_CNT_RST; // RQ10
        sh_out_q <= tx_byte;
      end
      else if (fall) // RQ11
      begin
        if (quad_rd)
        begin
          quad_out <= sh_out_q[7:4]; // RQ7
          sh_out_q <= {sh_out_q[3:0], 4'h0};
        end
        else
        begin
          so_out <= sh_out_q[7]; // RQ9
          sh_out_q <= {sh_out_q[6:0], 1'b0};
        end
        if (ocnt_q == last)
        begin
          ocnt_q <= `SFHP_CNT_RST;
          sh_out_q <= tx_byte;
          tx_load <= 1'b1;
        end
        else
          ocnt_q <= ocnt_q + 3'h1;
      end
    end
  end

  // Status flags, kept apart from the shifters so hold cannot gate them
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      frame_start <= 1'b0;
      frame_end <= 1'b0;
      hold_active <= 1'b0;
      busy_out <= 1'b0;
    end
    else
    begin
      frame_start <= cs_n_q & ~cs_n_s; // RQ10
      frame_end <= ~cs_n_q & cs_n_s; // RQ10
      hold_active <= hold_d;
      // Internal cycle status passes straight through hold
      busy_out <= busy_in; // RQ5
    end
  end

  // Drivers released when deselected or held
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      so_oe_n <= 1'b1;
      quad_oe_n <= `SFHP_OE_OFF;
    end
    else
    begin
      so_oe_n <= cs_n_s | hold_d | quad_in | quad_rd; // RQ3
      quad_oe_n <= (cs_n_s | ~quad_rd) ? `SFHP_OE_OFF : `SFHP_OE_ON; // RQ7
    end
  end
endmodule

// [tb/sfhp_monitor.sv]
// Hold pin checker
`timescale 1ns/1ps
module sfhp_chk
(
  // Inputs
  input wire clk,
  input wire nrst,
  input wire cs_n_pin,
  input wire sck_pin,
  input wire hold_float,
  input wire [1:0] lane_mode,
  input wire busy_in,
  // Outputs
  input wire so_oe_n,
  input wire [3:0] quad_oe_n,
  input wire rx_valid,
  input wire frame_start,
  input wire frame_end,
  input wire hold_active,
  input wire busy_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_held_so_off: assert property (
    hold_active |-> so_oe_n) else $error("so on");
  a_held_no_rx: assert property (
    $past(hold_active) |-> !rx_valid) else $error("rx");
  a_busy_passes: assert property (
    busy_out == $past(busy_in)) else $error("busy");
  a_cs_start: assert property (
    $fell(cs_n_pin) |-> ##[1:4] frame_start) else $error("start");
  a_cs_end: assert property (
    $rose(cs_n_pin) |-> ##[1:4] frame_end) else $error("end");
  a_hold_when_sel: assert property (
    $rose(hold_active) |-> !$past(cs_n_pin, 3) && !$past(sck_pin, 3))
    else $error("hold");
  a_float_no_hold: assert property (
    hold_float [*4] |-> !hold_active) else $error("float");
  a_quad_no_hold: assert property (
    lane_mode != 2'h0 |-> !hold_active) else $error("quad");
  cover property ($rose(hold_active));
  cover property (rx_valid && lane_mode == 2'h1);
  a_lanes_released: assert property (
    $past(lane_mode) != 2'h2 |-> quad_oe_n == 4'hf) else $error("lanes");
  cover property ($rose(cs_n_pin));
  cover property (quad_oe_n == 4'h0);
endmodule
bind sfhp_top sfhp_chk u_chk (.*);

// [tb/sfhp_host.sv]
// Host model driving frames onto the flash pins
`timescale 1ns/1ps
module sfhp_host
(
  // Clock and device outputs
  input wire clk,
  input wire so_out,
  input wire [3:0] quad_out,
  // Host pins and held window flag
  output reg cs_n_pin = 1'b1,
  output reg sck_pin = 1'b1,
  output reg [3:0] hio = 4'hf,
  output reg held = 1'b0
);
  task pause(input int hk);
  begin
    hio[3] <= 1'b0;
    repeat (6) @(posedge clk);
    held <= 1'b1;
    repeat (4)
    begin
      repeat (3) @(posedge clk);
      if (hk == 1)
        {sck_pin, hio[0]} <= ~{sck_pin, hio[0]};
    end
    @(posedge clk);
    {held, hio[3]} <= 2'b01;
    repeat (4) @(posedge clk);
  end
  endtask
  task frame(input [1:0] m, input [7:0] d, input int hb, hk,
    output [7:0] q);
    int i;
  begin
    @(posedge clk);
    cs_n_pin <= 1'b0;
    for (i = 0; i < (m ? 2 : 8); i++)
    begin
      repeat (4) @(posedge clk);
      sck_pin <= 1'b0;
      hio <= m ? d[7 - 4 * i -: 4] : {3'h7, d[7 - i]};
      // Five cycles so the output has settled before sampling
      repeat (5) @(posedge clk);
      if (i == hb && hk != 2)
        pause(hk);
      sck_pin <= 1'b1;
      q = m == 2 ? {q[3:0], quad_out} : {q[6:0], so_out};
      if (i == hb && hk == 2)
        pause(hk);
    end
    repeat (4) @(posedge clk);
    cs_n_pin <= 1'b1;
    hio <= ~hio;
    repeat (6) @(posedge clk);
  end
  endtask
endmodule

// [tb/spi_flash_hold_pause_tb_top.sv]
// Self-checking bench for the hold pin logic
`timescale 1ns/1ps
module spi_flash_hold_pause_tb_top;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg hold_float = 1'b0;
  reg busy_in = 1'b0;
  reg [1:0] lane_mode = 2'h0;
  reg [7:0] tx_byte = 8'h00;
  wire cs_n_pin, sck_pin, held, so_out, so_oe_n, rx_valid, hold_active;
  wire [3:0] hio, quad_out, quad_oe_n;
  wire [3:0] io_in = quad_out & ~quad_oe_n | hio & quad_oe_n;
  wire [7:0] rx_byte;
  wire tx_load, frame_start, frame_end;
  int seed = 59;
  int fail_count = 0;
  int n_compared = 0;
  int n_load = 0, n_start = 0, n_end = 0;
  int i, hk;
  reg [1:0] m;
  reg [7:0] d, q;
  reg [7:0] expq[$];
  always #4 clk = ~clk;
  always @(posedge clk)
    busy_in <= nrst && $random(seed) > 0;
  sfhp_top DUT (.*, .busy_out());
  sfhp_host host (.*);
  task chk(input [7:0] s, e);
  begin
    n_compared++;
    if (s !== e)
    begin
      fail_count++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  end
  endtask
  task conclude;
  begin
    if (fail_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  always @(negedge clk)
  begin
    if (rx_valid && expq.size() > 0)
      chk(rx_byte, expq.pop_front());
    if (held)
      chk({6'h0, hold_active, so_oe_n}, hk == 1 ? 8'h3 : 8'h0);
    if (tx_load)
      n_load++;
    if (frame_start)
      n_start++;
    if (frame_end)
      n_end++;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 7; i++)
    begin
      m = i < 5 ? 2'h0 : 2'(i - 4);
      hk = i > 0 && i < 5 ? (i - 1) % 3 + 1 : 0;
      d = 8'($random(seed));
      @(posedge clk);
      lane_mode <= m;
      tx_byte <= ~d;
      hold_float <= hk == 3;
      if (m < 2)
        expq.push_back(d);
      host.frame(m, d, 2 * i - 1, hk, q);
      if (m != 1)
        chk(q, ~d);
    end
    chk(8'(expq.size()), 8'h0);
    // One byte leaves, one frame opens and one closes per loop pass
    chk(8'(n_load), 8'h07);
    chk(8'(n_start), 8'h07);
    chk(8'(n_end), 8'h07);
    conclude;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    conclude;
  end
endmodule
